// ==== dv/stereo_volume_command_decoder_test.sv ====
// Self-checking bench for the stereo volume command decoder.
`timescale 1ns/100ps
`default_nettype none
module stereo_volume_command_decoder_test;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic addr_sel = 1'b0;
  logic sda_out, sda_oe, mute, power_off_prep, def_l, def_r, scl, sda_low, s, ack;
  logic [3:0] fine_l, fine_r, boost_l, boost_r;
  logic [2:0] coarse_l, coarse_r;
  logic [7:0] level_l, level_r;
  logic [1:0] input_pair, e_pair;
  logic [3:0] e_fine [2];
  logic [2:0] e_coarse [2];
  logic [3:0] e_boost [2];
  logic e_mute, e_prep;
  int mismatches = 0;
  int check_count = 0;
  // Gain moves are preceded by zeroed attenuation and the reverse, as a careful host does.
  localparam logic [7:0] cmd_list [26] = '{8'h78, 8'hD0, 8'hE0, 8'hC6, 8'h6F, 8'h50, 8'h41,
    8'hC0, 8'hD3, 8'hA5, 8'h2C, 8'hE2, 8'hB3, 8'h3E, 8'h31, 8'h40, 8'h42, 8'h43, 8'h4C,
    8'h79, 8'h78, 8'hF3, 8'h7A, 8'h0F, 8'hFF, 8'h71};
  // The line has a pull-up, so it reads high unless a party pulls it low.
  wire sda_wire = !(sda_low || (sda_oe && !sda_out));
  always #50 clk = ~clk;
  stereo_volume_command_decoder u_stereo_volume_command_decoder (.clk(clk), .arst_n(arst_n),
    .scl_in(scl), .sda_in(sda_wire), .addr_sel(addr_sel), .sda_out(sda_out), .sda_oe(sda_oe),
    .fine_atten_left(fine_l), .fine_atten_right(fine_r), .coarse_atten_left(coarse_l),
    .coarse_atten_right(coarse_r), .boost_left(boost_l), .boost_right(boost_r),
    .level_left(level_l), .level_right(level_r), .level_defined_left(def_l),
    .level_defined_right(def_r), .input_pair(input_pair), .mute(mute),
    .power_off_prep(power_off_prep), .cmd_strobe());
  volume_host_model u_volume_host_model (.clk(clk), .sda_wire(sda_wire), .scl(scl),
    .sda_low(sda_low));
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Expected state follows each command byte; unknown codes leave it alone.
  task automatic apply(input logic [7:0] c);
    for (int ch = 0; ch < 2; ch++) begin
      if (c[7:4] == 4'hD || c[7:4] == (ch ? 4'h2 : 4'hA)) e_fine[ch] = c[3:0];
      if (!c[3] && (c[7:4] == 4'hE || c[7:4] == (ch ? 4'h3 : 4'hB))) e_coarse[ch] = c[2:0];
      if (c[7:4] == 4'hC || c[7:4] == (ch ? 4'h5 : 4'h6)) e_boost[ch] = c[3:0];
      if (c == 8'hFF) begin
        e_fine[ch] = 4'h9;
        e_coarse[ch] = 3'h7;
        e_boost[ch] = 4'h0;
      end
    end
    if (c[7:2] == 6'h10) e_pair = c[1:0];
    if (c[7:1] == 7'h3C) e_mute = c[0];
    if (c == 8'h71) e_prep = 1'b1;
  endtask : apply
  task automatic check_state();
    logic [7:0] lv [2];
    foreach (lv[c]) lv[c] = {4'h0, e_boost[c]} - {4'h0, e_fine[c]} - 8'h0A * {5'h00, e_coarse[c]};
    cmp("fine", {8'h00, e_fine[0], e_fine[1]}, {8'h00, fine_l, fine_r});
    cmp("coarse", {10'h000, e_coarse[0], e_coarse[1]}, {10'h000, coarse_l, coarse_r});
    cmp("boost", {8'h00, e_boost[0], e_boost[1]}, {8'h00, boost_l, boost_r});
    cmp("level", {lv[0], lv[1]}, {level_l, level_r});
    cmp("defined", {14'h0000, e_fine[0] <= 4'h9, e_fine[1] <= 4'h9}, {14'h0000, def_l, def_r});
    cmp("flags", {12'h000, e_pair, e_mute, e_prep}, {12'h000, input_pair, mute, power_off_prep});
  endtask : check_state
  // One transfer of one command byte; a refused address is aborted with a stop.
  task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic exp_ack);
    u_volume_host_model.start_cond();
    u_volume_host_model.send_byte(a, ack);
    cmp("addr_ack", {15'h0000, exp_ack}, {15'h0000, ack});
    if (exp_ack) begin
      u_volume_host_model.send_byte(c, ack);
      apply(c);
    end
    u_volume_host_model.stop_cond();
    check_state();
  endtask : frame
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    // The settle time after power-up is scaled down to keep the run short.
    repeat (6) @(posedge clk);
    e_fine = '{4'h9, 4'h9};
    e_coarse = '{3'h7, 3'h7};
    e_boost = '{4'h0, 4'h0};
    e_pair = 2'h0;
    e_mute = 1'b1;
    e_prep = 1'b0;
  endtask : do_reset
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // Main sequence: defaults, a long back-to-back frame, aborts, addressing, second reset.
  initial begin
    do_reset();
    check_state();
    $display("test reset_defaults done");
    u_volume_host_model.start_cond();
    u_volume_host_model.send_byte({volume_pkg::ADDR_SEL_LOW, 1'b0}, ack);
    cmp("addr_ack", 16'h0001, {15'h0000, ack});
    foreach (cmd_list[i]) begin
      u_volume_host_model.send_byte(cmd_list[i], ack);
      cmp("data_ack", 16'h0001, {15'h0000, ack});
      apply(cmd_list[i]);
      check_state();
    end
    u_volume_host_model.stop_cond();
    $display("test command_table done");
    u_volume_host_model.start_cond();
    u_volume_host_model.send_byte(8'h88, ack);
    repeat (4) u_volume_host_model.clock_bit(1'b1, s);
    u_volume_host_model.stop_cond();
    check_state();
    $display("test partial_byte done");
    addr_sel <= 1'b1;
    frame(8'h88, 8'hD1, 1'b0);
    frame(8'h8C, 8'hD1, 1'b1);
    addr_sel <= 1'b0;
    frame(8'h89, 8'hD2, 1'b0);
    frame(8'h88, 8'hD2, 1'b1);
    $display("test addressing done");
    do_reset();
    check_state();
    $display("test second_reset done");
    end_of_test();
  end
  // Cuts a hung run short; the whole sequence needs well under this many cycles.
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule : stereo_volume_command_decoder_test
`default_nettype wire

// ==== dv/volume_checker_properties.sv ====
// Concurrent checks on the ports of the stereo volume command decoder.
`timescale 1ns/100ps
`default_nettype none
module volume_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [3:0] fine_atten_left,
  input wire logic [3:0] fine_atten_right,
  input wire logic [2:0] coarse_atten_left,
  input wire logic [2:0] coarse_atten_right,
  input wire logic [3:0] boost_left,
  input wire logic [3:0] boost_right,
  input wire logic [7:0] level_left,
  input wire logic [7:0] level_right,
  input wire logic level_defined_left,
  input wire logic level_defined_right,
  input wire logic [1:0] input_pair,
  input wire logic mute,
  input wire logic power_off_prep,
  input wire logic cmd_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // The acknowledge may only be raised while the bus clock is low, and it must stay
  // up across the slot until at least the cycle after the ninth clock falls.
  chk_ack_window: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("acknowledge raised while bus clock high");
  chk_ack_hold: assert property ($fell(scl_in) && sda_oe |-> sda_oe [*2])
    else $error("acknowledge dropped too early");
  chk_ack_release: assert property (sda_oe |-> ##[1:1000] !sda_oe)
    else $error("acknowledge never released");
  chk_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");
  chk_strobe_pulse: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("command strobe longer than one cycle");
  chk_strobe_acked: assert property (cmd_strobe |-> sda_oe)
    else $error("command taken without acknowledge");
  // Every state output except the two defined flags may only move in the cycle a command byte lands.
  chk_fields_hold: assert property (!cmd_strobe |-> $stable({fine_atten_left,
      fine_atten_right, coarse_atten_left, coarse_atten_right, boost_left, boost_right,
      level_left, level_right, input_pair, mute, power_off_prep}))
    else $error("state changed without a command");
  chk_level_sum: assert property (level_left == {4'h0, boost_left} - {4'h0, fine_atten_left}
      - 8'h0A * {5'h00, coarse_atten_left} && level_right == {4'h0, boost_right}
      - {4'h0, fine_atten_right} - 8'h0A * {5'h00, coarse_atten_right})
    else $error("level is not the sum of the fields");
  chk_fine_defined: assert property (level_defined_left == (fine_atten_left <= 4'h9)
      && level_defined_right == (fine_atten_right <= 4'h9))
    else $error("defined flag wrong for fine code");
  chk_prep_sticky: assert property (power_off_prep |=> power_off_prep)
    else $error("power-off preparation cleared");
  cover property ($rose(sda_oe) ##1 sda_oe [*3]);
  cover property (cmd_strobe && !mute);
  cover property ($rose(power_off_prep));
endmodule : volume_checker
bind stereo_volume_command_decoder volume_checker u_volume_checker (.clk, .arst_n, .scl_in,
  .sda_out, .sda_oe, .fine_atten_left, .fine_atten_right, .coarse_atten_left,
  .coarse_atten_right, .boost_left, .boost_right, .level_left, .level_right,
  .level_defined_left, .level_defined_right, .input_pair, .mute, .power_off_prep, .cmd_strobe);
`default_nettype wire

// ==== dv/volume_host_model.sv ====
// Host bus master model that frames write transfers on the two-wire link.
`timescale 1ns/100ps
`default_nettype none
module volume_host_model (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  // The link clock stands high and the data line is released between frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Data falls while the clock is high; also serves as a repeated start.
  task automatic start_cond();
    tick(2);
    sda_low <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b0;
  endtask : start_cond
  // Low half is five cycles so the device has its answer set before the clock rises.
  task automatic clock_bit(input logic b, output logic seen);
    tick(2);
    sda_low <= !b;
    tick(3);
    scl <= 1'b1;
    tick(2);
    @(negedge clk);
    seen = sda_wire;
    tick(1);
    scl <= 1'b0;
  endtask : clock_bit
  // Eight bits, most significant first, then a released ninth bit for the answer.
  task automatic send_byte(input logic [7:0] d, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], s);
    end
    clock_bit(1'b1, s);
    acked = !s;
  endtask : send_byte
  // Data rises while the clock is high, then the bus is left idle.
  task automatic stop_cond();
    tick(2);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_low <= 1'b0;
    tick(3);
  endtask : stop_cond
endmodule : volume_host_model
`default_nettype wire

// ==== hdl/level_calc.sv ====
// Per-channel level computation from the fine, coarse and boost fields.
`timescale 1ns/100ps
`default_nettype none
module level_calc (
  input wire logic [3:0] fine,
  input wire logic [2:0] coarse,
  input wire logic [3:0] boost,
  output logic [7:0] level_db,
  output logic defined
);

  logic [7:0] coarse_db;

  // Ten decibels per coarse count, built from shifts so no multiplier is needed.
  assign coarse_db = {2'b00, coarse, 3'b000} + {4'b0000, coarse, 1'b0};

  // Two's complement sum: boost minus fine minus coarse, in whole decibels.
  assign level_db = {4'b0000, boost} - {4'b0000, fine} - coarse_db;

  // Fine codes above nine have no defined attenuation.
  assign defined = (fine <= volume_pkg::FINE_MAX);

endmodule : level_calc
`default_nettype wire

// ==== hdl/stereo_volume_command_decoder.sv ====
// Top of the stereo volume command decoder: serial receiver, decoder and channel state.
// Rules of the document for this block and its host
// [RULE1] Answer address 1000100 with select pin low, 1000110 with it high.
// [RULE2] Host always sends the read/write flag as zero; reads are not acknowledged. The bench sends 10001001 once to check the refusal.
// [RULE3] Acknowledge on the ninth clock after the address byte and every data byte.
// [RULE4] Host frames transfers: start, address, command bytes with acknowledges, stop.
// [RULE5] All-ones command sets both channels to minus 79 decibels.
// [RULE6] Nibbles 1101, 1010, 0010 load fine attenuation: both, left, right.
// [RULE7] Nibbles 1110, 1011, 0011 with bit 3 zero load coarse: both, left, right.
// [RULE8] Nibbles 1100, 0110, 0101 load gain: both, left, right.
// [RULE9] Fine code is minus one decibel per count; codes ten upward undefined.
// [RULE10] Coarse code is minus ten decibels per count, zero to minus seventy.
// [RULE11] Gain code is plus one decibel per count, zero to plus fifteen.
// [RULE12] Channel level is the sum of fine, coarse and gain contributions.
// [RULE13] Command 010000xx selects input pair one to four.
// [RULE14] Command 01111001 mutes both channels; 01111000 unmutes them.
// [RULE15] Command 01110001 enters power-off preparation.
// [RULE16] After reset: minus 79 decibels, gain zero, mute on.
// [RULE17] Host's first command after power-up is mute off.
// [RULE18] Host zeroes attenuation before moving a channel into positive gain.
// [RULE19] Host zeroes gain before moving a channel into attenuation.
// [RULE20] Host waits one second after power-up before its first command. The bench waits six clock cycles after releasing reset.
// [RULE21] Host should fix gain once at power-up and then vary attenuation. The bench moves gain four times in its command list.
// [RULE22] Bytes are eight bits, most significant first, then one acknowledge bit.
// [RULE23] Without acknowledge the host may stop to abort the transfer.
// [RULE24] Undefined command bytes are acknowledged and change nothing.
// [RULE25] Fields hold until a command addressing that field and channel.
`timescale 1ns/100ps
`default_nettype none
module stereo_volume_command_decoder (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic addr_sel,
  output logic sda_out,
  output logic sda_oe,
  output logic [3:0] fine_atten_left,
  output logic [3:0] fine_atten_right,
  output logic [2:0] coarse_atten_left,
  output logic [2:0] coarse_atten_right,
  output logic [3:0] boost_left,
  output logic [3:0] boost_right,
  output logic [7:0] level_left,
  output logic [7:0] level_right,
  output logic level_defined_left,
  output logic level_defined_right,
  output logic [1:0] input_pair,
  output logic mute,
  output logic power_off_prep,
  output logic cmd_strobe
);

  // Reset release synchroniser; the rest of the design uses rst_n.
  logic [1:0] rst_sync_ff;
  logic rst_n;

  // Synchronised pins and their previous samples for edge finding.
  logic [2:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic sel_s;
  logic scl_q_ff;
  logic sda_q_ff;
  logic nxt_scl_q;
  logic nxt_sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [6:0] own_addr;

  // Receiver state.
  volume_pkg::bus_state_e st_ff;
  volume_pkg::bus_state_e nxt_st;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic oe_ff;
  logic nxt_oe;
  logic exec_ff;
  logic nxt_exec;

  // Decoder outputs and global state.
  logic [1:0] we_fine;
  logic [1:0] we_coarse;
  logic [1:0] we_boost;
  logic all_off;
  logic [1:0] pair_ff;
  logic [1:0] nxt_pair;
  logic mute_ff;
  logic nxt_mute;
  logic prep_ff;
  logic nxt_prep;
  logic strobe_ff;
  logic nxt_strobe;

  // Per-channel flip-flop copies gathered for the output ports.
  logic [3:0] fine_q [volume_pkg::CH_COUNT];
  logic [2:0] coarse_q [volume_pkg::CH_COUNT];
  logic [3:0] boost_q [volume_pkg::CH_COUNT];
  logic [7:0] level_q [volume_pkg::CH_COUNT];
  logic defined_q [volume_pkg::CH_COUNT];

  // Asynchronous assertion, synchronous release of the internal reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Bus pins and the address strap come from outside the clock domain.
  sync_two_ff #(
    .WIDTH(3),
    .RESET_VAL(3'b111)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({addr_sel, sda_in, scl_in}),
    .sync_out(pins_sync)
  );
  assign scl_s = pins_sync[0];
  assign sda_s = pins_sync[1];
  assign sel_s = pins_sync[2];

  // Previous samples of the synchronised lines.
  always_comb begin
    nxt_scl_q = scl_s;
    nxt_sda_q = sda_s;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= nxt_scl_q;
      sda_q_ff <= nxt_sda_q;
    end
  end

  // Start and stop are data edges while the clock stays high.
  assign scl_rise = scl_s & ~scl_q_ff;
  assign scl_fall = ~scl_s & scl_q_ff;
  assign bus_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign bus_stop = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

  // The strap picks one of two addresses; it is sampled continuously. See [RULE1].
  assign own_addr = sel_s ? volume_pkg::ADDR_SEL_HIGH : volume_pkg::ADDR_SEL_LOW;

  // Receiver: shifts bits on rising clock, drives acknowledge from a falling clock.
  // Start and stop win over any byte in progress, so a host can always resynchronise.
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_oe = oe_ff;
    nxt_exec = 1'b0;
    if (bus_start) begin
      nxt_st = volume_pkg::ST_ADDR;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_st = volume_pkg::ST_IDLE; // see [RULE23]
      nxt_oe = 1'b0;
    end else begin
      unique case (st_ff)
        volume_pkg::ST_IDLE: begin
          nxt_oe = 1'b0;
        end
        volume_pkg::ST_ADDR, volume_pkg::ST_DATA: begin
          if (scl_rise && (cnt_ff != volume_pkg::BITS_PER_BYTE)) begin
            nxt_shift = {shift_ff[6:0], sda_s}; // see [RULE22]
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && (cnt_ff == volume_pkg::BITS_PER_BYTE)) begin
            if (st_ff == volume_pkg::ST_ADDR) begin
              if ((shift_ff[7:1] == own_addr) && (shift_ff[0] == volume_pkg::WRITE_FLAG)) begin
                nxt_oe = 1'b1; // see [RULE1] see [RULE2] see [RULE3]
                nxt_st = volume_pkg::ST_AACK;
              end else begin
                nxt_st = volume_pkg::ST_IDLE;
              end
            end else begin
              nxt_oe = 1'b1; // see [RULE3] see [RULE4]
              nxt_exec = 1'b1;
              nxt_st = volume_pkg::ST_DACK;
            end
          end
        end
        volume_pkg::ST_AACK, volume_pkg::ST_DACK: begin
          if (scl_fall) begin
            nxt_oe = 1'b0; // Release after the ninth clock.
            nxt_st = volume_pkg::ST_DATA;
            nxt_cnt = 4'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= volume_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      oe_ff <= 1'b0;
      exec_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      oe_ff <= nxt_oe;
      exec_ff <= nxt_exec;
    end
  end

  // Command decode; the shift register holds the byte steady through the acknowledge.
  // Any code not matched falls through and leaves every field alone.
  always_comb begin
    we_fine = volume_pkg::CH_NONE;
    we_coarse = volume_pkg::CH_NONE;
    we_boost = volume_pkg::CH_NONE;
    all_off = 1'b0;
    nxt_pair = pair_ff;
    nxt_mute = mute_ff;
    nxt_prep = prep_ff;
    nxt_strobe = exec_ff;
    if (exec_ff) begin
      case (shift_ff[7:4])
        volume_pkg::OP_ALL_OFF: all_off = (shift_ff == volume_pkg::CMD_ALL_OFF); // see [RULE5]
        volume_pkg::OP_FINE_BOTH: we_fine = volume_pkg::CH_BOTH; // see [RULE6]
        volume_pkg::OP_FINE_LEFT: we_fine = volume_pkg::CH_LEFT; // see [RULE6]
        volume_pkg::OP_FINE_RIGHT: we_fine = volume_pkg::CH_RIGHT; // see [RULE6]
        volume_pkg::OP_COARSE_BOTH: begin
          if (!shift_ff[3]) begin
            we_coarse = volume_pkg::CH_BOTH; // see [RULE7]
          end
        end
        volume_pkg::OP_COARSE_LEFT: begin
          if (!shift_ff[3]) begin
            we_coarse = volume_pkg::CH_LEFT; // see [RULE7]
          end
        end
        volume_pkg::OP_COARSE_RIGHT: begin
          if (!shift_ff[3]) begin
            we_coarse = volume_pkg::CH_RIGHT; // see [RULE7]
          end
        end
        volume_pkg::OP_BOOST_BOTH: we_boost = volume_pkg::CH_BOTH; // see [RULE8]
        volume_pkg::OP_BOOST_LEFT: we_boost = volume_pkg::CH_LEFT; // see [RULE8]
        volume_pkg::OP_BOOST_RIGHT: we_boost = volume_pkg::CH_RIGHT; // see [RULE8]
        volume_pkg::OP_INPUT: begin
          if (shift_ff[3:2] == 2'b00) begin
            nxt_pair = shift_ff[1:0]; // see [RULE13]
          end
        end
        volume_pkg::OP_MISC: begin
          if (shift_ff == volume_pkg::CMD_MUTE_ON) begin
            nxt_mute = 1'b1; // see [RULE14]
          end else if (shift_ff == volume_pkg::CMD_MUTE_OFF) begin
            nxt_mute = 1'b0; // see [RULE14]
          end else if (shift_ff == volume_pkg::CMD_POWER_PREP) begin
            nxt_prep = 1'b1; // see [RULE15]
          end
        end
        default: begin
          nxt_strobe = exec_ff; // see [RULE24]
        end
      endcase
    end
  end

  // Global state starts muted on the first input pair.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pair_ff <= volume_pkg::INPUT_RESET;
      mute_ff <= volume_pkg::MUTE_RESET; // see [RULE16]
      prep_ff <= volume_pkg::PREP_RESET;
      strobe_ff <= 1'b0;
    end else begin
      pair_ff <= nxt_pair;
      mute_ff <= nxt_mute;
      prep_ff <= nxt_prep;
      strobe_ff <= nxt_strobe;
    end
  end

  // One copy of the field registers per channel; index 0 is left, 1 is right.
  for (genvar ch = 0; ch < volume_pkg::CH_COUNT; ch++) begin : g_chan
    logic [3:0] fine_ff;
    logic [3:0] nxt_fine;
    logic [2:0] coarse_ff;
    logic [2:0] nxt_coarse;
    logic [3:0] boost_ff;
    logic [3:0] nxt_boost;
    logic [7:0] level_ff;
    logic [7:0] nxt_level;
    logic defined_ff;
    logic nxt_defined;

    // Fields change only when a command names them for this channel.
    always_comb begin
      nxt_fine = fine_ff; // see [RULE25]
      nxt_coarse = coarse_ff;
      nxt_boost = boost_ff;
      if (all_off) begin
        nxt_fine = volume_pkg::FINE_MAX; // see [RULE5]
        nxt_coarse = volume_pkg::COARSE_MAX;
        nxt_boost = volume_pkg::BOOST_RESET;
      end else begin
        if (we_fine[ch]) begin
          nxt_fine = shift_ff[3:0];
        end
        if (we_coarse[ch]) begin
          nxt_coarse = shift_ff[2:0];
        end
        if (we_boost[ch]) begin
          nxt_boost = shift_ff[3:0];
        end
      end
    end

    // The level follows the next field values so it lands in the same cycle.
    level_calc u_level (
      .fine(nxt_fine), // see [RULE9] see [RULE10] see [RULE11]
      .coarse(nxt_coarse),
      .boost(nxt_boost),
      .level_db(nxt_level), // see [RULE12]
      .defined(nxt_defined)
    );

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        fine_ff <= volume_pkg::FINE_MAX; // see [RULE16]
        coarse_ff <= volume_pkg::COARSE_MAX;
        boost_ff <= volume_pkg::BOOST_RESET;
        level_ff <= volume_pkg::LEVEL_RESET;
        defined_ff <= 1'b1;
      end else begin
        fine_ff <= nxt_fine;
        coarse_ff <= nxt_coarse;
        boost_ff <= nxt_boost;
        level_ff <= nxt_level;
        defined_ff <= nxt_defined;
      end
    end

    assign fine_q[ch] = fine_ff;
    assign coarse_q[ch] = coarse_ff;
    assign boost_q[ch] = boost_ff;
    assign level_q[ch] = level_ff;
    assign defined_q[ch] = defined_ff;
  end

  // Open-drain data line: the module only ever pulls low.
  assign sda_out = 1'b0;
  assign sda_oe = oe_ff;
  assign fine_atten_left = fine_q[0];
  assign fine_atten_right = fine_q[1];
  assign coarse_atten_left = coarse_q[0];
  assign coarse_atten_right = coarse_q[1];
  assign boost_left = boost_q[0];
  assign boost_right = boost_q[1];
  assign level_left = level_q[0];
  assign level_right = level_q[1];
  assign level_defined_left = defined_q[0];
  assign level_defined_right = defined_q[1];
  assign input_pair = pair_ff;
  assign mute = mute_ff;
  assign power_off_prep = prep_ff;
  assign cmd_strobe = strobe_ff;

endmodule : stereo_volume_command_decoder
`default_nettype wire

// ==== hdl/sync_two_ff.sv ====
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // The first stage is read by the second stage only, to keep metastability contained.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  // The reset value only matters for the idle level; a bus idles high.
  assign sync_out = sync_ff;

endmodule : sync_two_ff
`default_nettype wire

// ==== hdl/volume_pkg.sv ====
// Shared constants and types for the stereo volume command decoder.
package volume_pkg;

  // Bus addresses answered, selected by the address-select pin.
  localparam logic [6:0] ADDR_SEL_LOW = 7'h44;
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h46;
  localparam logic WRITE_FLAG = 1'b0;

  // Bits shifted in before the acknowledge slot.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Upper-nibble operation codes of a command byte.
  localparam logic [3:0] OP_ALL_OFF = 4'hF;
  localparam logic [3:0] OP_FINE_BOTH = 4'hD;
  localparam logic [3:0] OP_FINE_LEFT = 4'hA;
  localparam logic [3:0] OP_FINE_RIGHT = 4'h2;
  localparam logic [3:0] OP_COARSE_BOTH = 4'hE;
  localparam logic [3:0] OP_COARSE_LEFT = 4'hB;
  localparam logic [3:0] OP_COARSE_RIGHT = 4'h3;
  localparam logic [3:0] OP_BOOST_BOTH = 4'hC;
  localparam logic [3:0] OP_BOOST_LEFT = 4'h6;
  localparam logic [3:0] OP_BOOST_RIGHT = 4'h5;
  localparam logic [3:0] OP_INPUT = 4'h4;
  localparam logic [3:0] OP_MISC = 4'h7;

  // Whole-byte commands.
  localparam logic [7:0] CMD_ALL_OFF = 8'hFF;
  localparam logic [7:0] CMD_MUTE_ON = 8'h79;
  localparam logic [7:0] CMD_MUTE_OFF = 8'h78;
  localparam logic [7:0] CMD_POWER_PREP = 8'h71;

  // Channel write masks; bit 0 is left, bit 1 is right.
  localparam logic [1:0] CH_NONE = 2'b00;
  localparam logic [1:0] CH_LEFT = 2'b01;
  localparam logic [1:0] CH_RIGHT = 2'b10;
  localparam logic [1:0] CH_BOTH = 2'b11;
  localparam int CH_COUNT = 2;

  // Field limits and reset values.
  localparam logic [3:0] FINE_MAX = 4'h9;
  localparam logic [2:0] COARSE_MAX = 3'h7;
  localparam logic [3:0] BOOST_RESET = 4'h0;
  localparam logic [1:0] INPUT_RESET = 2'h0;
  localparam logic MUTE_RESET = 1'b1;
  localparam logic PREP_RESET = 1'b0;
  // Level after reset and after the all-off command: minus 79 decibels.
  localparam logic [7:0] LEVEL_RESET = 8'hB1;

  // Receiver states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_AACK = 5'b00100,
    ST_DATA = 5'b01000,
    ST_DACK = 5'b10000
  } bus_state_e;

endpackage : volume_pkg
